// ===== hdl/rcr_defs.vh
// Register offsets, field positions, reset values and timing figures
`ifndef RCR_DEFS_VH
`define RCR_DEFS_VH

// Byte offsets of the register words
`define RCR_OFS_ADC_SUPPORT 8'h00
`define RCR_OFS_GAIN_SEL_0 8'h04
`define RCR_OFS_GAIN_SEL_1 8'h08
`define RCR_OFS_ANGLE_CMP_0 8'h0c
`define RCR_OFS_ANGLE_CMP_1 8'h10
`define RCR_OFS_ANGLE_CMP_2 8'h14
`define RCR_OFS_SC_ANGLE_COR 8'h18
`define RCR_OFS_SC_COR_1 8'h1c
`define RCR_OFS_SC_COR_2 8'h20
`define RCR_OFS_SC_COR_3 8'h24
`define RCR_OFS_ERR_DET_0 8'h30
`define RCR_OFS_ERR_DET_1 8'h34
`define RCR_OFS_ERR_DET_2 8'h38
`define RCR_OFS_ERR_OUT_0 8'h3c
`define RCR_OFS_ERR_OUT_1 8'h40
`define RCR_OFS_SELF_TEST_0 8'h44
`define RCR_OFS_SELF_TEST_1 8'h48
`define RCR_OFS_EXC_SETTING 8'h4c
`define RCR_OFS_PULSE_OUT_0 8'h50
`define RCR_OFS_PULSE_OUT_1 8'h54
`define RCR_OFS_PULSE_OUT_2 8'h58
`define RCR_OFS_ANG_VELOCITY 8'h5c
`define RCR_OFS_MONITOR 8'h60
`define RCR_OFS_TEST_BUS 8'h64
`define RCR_OFS_EXC_TMR_CTRL 8'h6c
`define RCR_OFS_EXC_TMR_CAP 8'h70
`define RCR_OFS_ZERO_CROSS 8'h74
`define RCR_OFS_ERR_DET_3 8'hb0
`define RCR_OFS_ERR_DET_4 8'hb4
`define RCR_OFS_DEBUG_0 8'hc0
`define RCR_OFS_DEBUG_1 8'hc4
`define RCR_OFS_DEBUG_3 8'hcc

// Support register field positions
`define RCR_GRP_DELAY_MSB 5
`define RCR_GRP_DELAY_LSB 4
`define RCR_UPD_RATE_MSB 1
`define RCR_UPD_RATE_LSB 0
// Writable bits of the support register
`define RCR_ADC_SUPPORT_MASK 32'h00000033

// Reset values
`define RCR_ADC_SUPPORT_RST 32'h00000000
`define RCR_GENERIC_RST 32'h00000000

// Group delay figures in nanoseconds per code
`define RCR_GRP_DELAY_0_NS 15000
`define RCR_GRP_DELAY_1_NS 10000
`define RCR_GRP_DELAY_2_NS 32000
`define RCR_GRP_DELAY_3_NS 4500
// Update rate figures in kilohertz per code
`define RCR_UPD_RATE_0_KHZ 100
`define RCR_UPD_RATE_1_KHZ 200
`define RCR_UPD_RATE_2_KHZ 400
`define RCR_UPD_RATE_3_KHZ 100
// Clock period in picoseconds and rate in kilohertz
`define RCR_CLK_PERIOD_PS 8000
`define RCR_CLK_KHZ 125000

`endif

// ===== hdl/rcr_regs.v
// Register bank of the resolver converter with Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
`include "rcr_defs.vh"
// What this block does
// - Every register takes byte, half and word access
// - Narrow accesses land on matching word lanes
// - Bits 5:4 select assumed converter group delay
// - Bits 1:0 select assumed converter update rate
// - Reserved support bits always read zero
// - Support register resets to all zeros

// How it behaves on the bus:
// - A request seen while idle is answered one cycle later.
// - Waitrequest is low for that single answering cycle.
// - A write lands at the answering edge, lanes by byteenable.
// - Read data is captured at the taking edge and stands
//   through the answering edge; it is always the whole word.
// - Requests may follow back to back; nothing is refused.
// Limits a user must know:
// - Bits 1:0 of the address never select a register.
// - Decoded settings lag the support word by one clock.
// - The 4.5 us delay is not a whole number of clocks and
//   is rounded down.
// - Writes to the debug words are dropped without notice.
module rcr_regs #(
    parameter NUM_REGS = 32,
    parameter NUM_RW = 29
) (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // Avalon-MM slave
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // Live values of the read-only debug words
    input wire [31:0] debug_0_i,
    input wire [31:0] debug_1_i,
    input wire [31:0] debug_3_i,
    // Decoded converter settings
    output reg [1:0] group_delay_select_o,
    output reg [1:0] update_rate_select_o,
    output reg [15:0] group_delay_cycles_o,
    output reg [10:0] sample_period_cycles_o,
    // Writable register words packed, index 1 at bits 31:0
    output wire [NUM_RW*32-1:0] ctrl_words_o
);

    //------------------------------------------------------------
    // Timing counts derived from the time figures
    //------------------------------------------------------------
    // Group delay in clocks, rounded down, full width first
    // 4.5 us gives 562.5 clocks, the half clock is dropped
    localparam integer DLY0_INT =
        `RCR_GRP_DELAY_0_NS * 1000 / `RCR_CLK_PERIOD_PS;
    localparam integer DLY1_INT =
        `RCR_GRP_DELAY_1_NS * 1000 / `RCR_CLK_PERIOD_PS;
    localparam integer DLY2_INT =
        `RCR_GRP_DELAY_2_NS * 1000 / `RCR_CLK_PERIOD_PS;
    localparam integer DLY3_INT =
        `RCR_GRP_DELAY_3_NS * 1000 / `RCR_CLK_PERIOD_PS;
    // Cut to the output width on purpose
    localparam [15:0] DLY0_CYC = DLY0_INT[15:0];
    localparam [15:0] DLY1_CYC = DLY1_INT[15:0];
    localparam [15:0] DLY2_CYC = DLY2_INT[15:0];
    localparam [15:0] DLY3_CYC = DLY3_INT[15:0];
    // Sample period in clocks, full width first
    localparam integer PER0_INT = `RCR_CLK_KHZ / `RCR_UPD_RATE_0_KHZ;
    localparam integer PER1_INT = `RCR_CLK_KHZ / `RCR_UPD_RATE_1_KHZ;
    localparam integer PER2_INT = `RCR_CLK_KHZ / `RCR_UPD_RATE_2_KHZ;
    localparam integer PER3_INT = `RCR_CLK_KHZ / `RCR_UPD_RATE_3_KHZ;
    // Cut to the output width on purpose
    localparam [10:0] PER0_CYC = PER0_INT[10:0];
    localparam [10:0] PER1_CYC = PER1_INT[10:0];
    localparam [10:0] PER2_CYC = PER2_INT[10:0];
    localparam [10:0] PER3_CYC = PER3_INT[10:0];

    //------------------------------------------------------------
    // Handshake state
    //------------------------------------------------------------
    // States, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;
    reg [1:0] state; // Slave phase
    reg [1:0] next_state; // Next phase
    wire req; // Request present
    assign req = avs_read_i | avs_write_i;

    // Waitrequest drops in the answer cycle only
    assign avs_waitrequest_o = ~(state == ST_DONE);

    // Idle waits for a request, done answers it for one cycle.
    // A request still high in done is the old one and is not
    // taken again; the master drops it at the answering edge.
    // Phase advance
    always @* begin
        case (state)
            ST_IDLE: next_state = req ? ST_DONE : ST_IDLE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Phase register
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    //------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------
    // Slot map of the bank:
    //   slot 0  delay and rate support word, own logic
    //   slot 1  control gain select 0
    //   slot 2  control gain select 1
    //   slot 3  angle compare 0
    //   slot 4  angle compare 1
    //   slot 5  angle compare 2
    //   slot 6  sine and cosine angle correction
    //   slot 7  sine and cosine correction 1
    //   slot 8  sine and cosine correction 2
    //   slot 9  sine and cosine correction 3
    //   slot 10 error detect 0
    //   slot 11 error detect 1
    //   slot 12 error detect 2
    //   slot 13 error output 0
    //   slot 14 error output 1
    //   slot 15 self test 0
    //   slot 16 self test 1
    //   slot 17 excitation setting
    //   slot 18 pulse output 0
    //   slot 19 pulse output 1
    //   slot 20 pulse output 2
    //   slot 21 angular velocity
    //   slot 22 monitor signal
    //   slot 23 test bus
    //   slot 24 excitation timer control
    //   slot 25 excitation timer capture
    //   slot 26 zero cross counter
    //   slot 27 error detect 3
    //   slot 28 error detect 4
    //   slot 29 spare, always zero
    // Debug words at the top are fed live by ports.
    // Every other offset reads zero and drops writes.
    // Word-aligned offset of each writable slot
    function [7:0] rw_ofs;
        input integer idx;
        begin
            case (idx)
                1: rw_ofs = `RCR_OFS_GAIN_SEL_0;
                2: rw_ofs = `RCR_OFS_GAIN_SEL_1;
                3: rw_ofs = `RCR_OFS_ANGLE_CMP_0;
                4: rw_ofs = `RCR_OFS_ANGLE_CMP_1;
                5: rw_ofs = `RCR_OFS_ANGLE_CMP_2;
                6: rw_ofs = `RCR_OFS_SC_ANGLE_COR;
                7: rw_ofs = `RCR_OFS_SC_COR_1;
                8: rw_ofs = `RCR_OFS_SC_COR_2;
                9: rw_ofs = `RCR_OFS_SC_COR_3;
                10: rw_ofs = `RCR_OFS_ERR_DET_0;
                11: rw_ofs = `RCR_OFS_ERR_DET_1;
                12: rw_ofs = `RCR_OFS_ERR_DET_2;
                13: rw_ofs = `RCR_OFS_ERR_OUT_0;
                14: rw_ofs = `RCR_OFS_ERR_OUT_1;
                15: rw_ofs = `RCR_OFS_SELF_TEST_0;
                16: rw_ofs = `RCR_OFS_SELF_TEST_1;
                17: rw_ofs = `RCR_OFS_EXC_SETTING;
                18: rw_ofs = `RCR_OFS_PULSE_OUT_0;
                19: rw_ofs = `RCR_OFS_PULSE_OUT_1;
                20: rw_ofs = `RCR_OFS_PULSE_OUT_2;
                21: rw_ofs = `RCR_OFS_ANG_VELOCITY;
                22: rw_ofs = `RCR_OFS_MONITOR;
                23: rw_ofs = `RCR_OFS_TEST_BUS;
                24: rw_ofs = `RCR_OFS_EXC_TMR_CTRL;
                25: rw_ofs = `RCR_OFS_EXC_TMR_CAP;
                26: rw_ofs = `RCR_OFS_ZERO_CROSS;
                27: rw_ofs = `RCR_OFS_ERR_DET_3;
                28: rw_ofs = `RCR_OFS_ERR_DET_4;
                default: rw_ofs = `RCR_OFS_ADC_SUPPORT;
            endcase
        end
    endfunction

    // Bits 1:0 never pick a register, only the lanes do
    // Aligned word address, byte lanes carried by byteenable
    wire [7:0] word_addr;
    assign word_addr = {avs_address_i[7:2], 2'b00};

    // A narrow write leaves the other lanes alone
    // Byte-lane write mask
    wire [31:0] lane_mask;
    assign lane_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                        {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // Only one edge per access may store
    // Write takes effect in the answer cycle
    wire wr_fire;
    assign wr_fire = (state == ST_DONE) & avs_write_i;

    //------------------------------------------------------------
    // Support register
    //------------------------------------------------------------
    reg [31:0] adc_setting_support; // Delay and rate selects
    // Only fields 5:4 and 1:0 are kept, the mask drops the rest
    // Zero after reset
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adc_setting_support <= `RCR_ADC_SUPPORT_RST;
        end else if (wr_fire && word_addr == `RCR_OFS_ADC_SUPPORT) begin
            adc_setting_support <= ((avs_writedata_i & lane_mask) |
                (adc_setting_support & ~lane_mask)) &
                `RCR_ADC_SUPPORT_MASK;
        end
    end

    //------------------------------------------------------------
    // Generic read-write words
    //------------------------------------------------------------
    // Slot 0 is the support register, kept apart above
    reg [31:0] rw_word [1:NUM_RW]; // Generic word store
    wire [NUM_RW:1] rw_hit; // Per-slot address match
    integer wi; // Slot walker of the store process
    genvar gi;
    // Per-slot decode and output wiring
    generate
        for (gi = 1; gi <= NUM_RW - 1; gi = gi + 1) begin : g_rw
            // Slot answers at its own offset only
            assign rw_hit[gi] = (word_addr == rw_ofs(gi));
            // Live copy to the converter core
            assign ctrl_words_o[gi*32-1 -: 32] = rw_word[gi];
        end
    endgenerate
    // Spare top slot never matches and stays zero
    assign rw_hit[NUM_RW] = 1'b0;
    assign ctrl_words_o[NUM_RW*32-1 -: 32] = rw_word[NUM_RW];

    // One process owns the whole store, so each word has one driver
    // Any width write
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Unknown reset contents, cleared to zero
            for (wi = 1; wi <= NUM_RW; wi = wi + 1) begin
                rw_word[wi] <= `RCR_GENERIC_RST;
            end
        end else if (wr_fire) begin
            for (wi = 1; wi <= NUM_RW; wi = wi + 1) begin
                if (rw_hit[wi]) begin
                    rw_word[wi] <= (avs_writedata_i & lane_mask) |
                        (rw_word[wi] & ~lane_mask);
                end
            end
        end
    end

    //------------------------------------------------------------
    // Read multiplexer
    //------------------------------------------------------------
    reg [31:0] next_rdata; // Word selected by address
    integer ri; // Slot walker of the read mux
    // Pick the addressed word, later matches win
    always @* begin
        // Nothing matched reads zero
        next_rdata = 32'h00000000;
        for (ri = 1; ri < NUM_RW; ri = ri + 1) begin
            if (rw_hit[ri]) begin
                next_rdata = rw_word[ri];
            end
        end
        // Words with logic of their own win over the slots
        case (word_addr)
            `RCR_OFS_ADC_SUPPORT: begin
                next_rdata = adc_setting_support & `RCR_ADC_SUPPORT_MASK;
            end
            // Debug words, live from the core
            `RCR_OFS_DEBUG_0: next_rdata = debug_0_i;
            `RCR_OFS_DEBUG_1: next_rdata = debug_1_i;
            `RCR_OFS_DEBUG_3: next_rdata = debug_3_i;
            default: begin
                // Keep the slot choice
            end
        endcase
    end

    // Captured at the taking edge so it stands at the answer
    // Holds until the next read, writes leave it alone
    // Read data registered, valid while waitrequest is low
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (state == ST_IDLE && avs_read_i) begin
            // Whole word returned, master picks lanes
            avs_readdata_o <= next_rdata;
        end
    end

    //------------------------------------------------------------
    // Setting decode
    //------------------------------------------------------------
    // Field slices of the support word
    wire [1:0] dly_sel; // Group delay code
    wire [1:0] rate_sel; // Update rate code
    assign dly_sel =
        adc_setting_support[`RCR_GRP_DELAY_MSB:`RCR_GRP_DELAY_LSB];
    assign rate_sel =
        adc_setting_support[`RCR_UPD_RATE_MSB:`RCR_UPD_RATE_LSB];

    // Raw select codes to the converter core
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            group_delay_select_o <= 2'h0;
            update_rate_select_o <= 2'h0;
        end else begin
            group_delay_select_o <= dly_sel;
            update_rate_select_o <= rate_sel;
        end
    end

    // Group delay code to clock count
    // Delay code to cycles
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            group_delay_cycles_o <= 16'h0000;
        end else begin
            case (dly_sel)
                // 15 us, the reset choice
                2'h0: group_delay_cycles_o <= DLY0_CYC;
                // 10 us
                2'h1: group_delay_cycles_o <= DLY1_CYC;
                // 32 us
                2'h2: group_delay_cycles_o <= DLY2_CYC;
                // 4.5 us, half a clock short
                default: group_delay_cycles_o <= DLY3_CYC;
            endcase
        end
    end

    // Update rate code to sample period
    // Rate code to period
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_period_cycles_o <= 11'h000;
        end else begin
            case (rate_sel)
                // 100 kHz, the reset choice
                2'h0: sample_period_cycles_o <= PER0_CYC;
                // 200 kHz
                2'h1: sample_period_cycles_o <= PER1_CYC;
                // 400 kHz
                2'h2: sample_period_cycles_o <= PER2_CYC;
                // 100 kHz again
                default: sample_period_cycles_o <= PER3_CYC;
            endcase
        end
    end

endmodule // rcr_regs
`default_nettype wire

// ===== tb/rcr_regs_props.sv
// Assertion checker for the resolver converter register bank
`timescale 1ns/1ps
`default_nettype none
module rcr_regs_props (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // Bus side
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire [31:0] debug_0_i,
    // Decoded settings
    input wire [1:0] group_delay_select_o,
    input wire [1:0] update_rate_select_o,
    input wire [15:0] group_delay_cycles_o,
    input wire [10:0] sample_period_cycles_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (!rst_n_i);
// Completed read and completed low-lane write to the support word
wire rd_done = avs_read_i && !avs_waitrequest_o;
wire wr_sup = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00
    && avs_byteenable_i[0];
// Delay code to clock cycles at 125 MHz
function automatic [15:0] gd_c(input [1:0] c);
    gd_c = c == 2'h0 ? 16'h0753 : c == 2'h1 ? 16'h04e2 :
        c == 2'h2 ? 16'h0fa0 : 16'h0232;
endfunction
// Rate code to sample period in cycles
function automatic [10:0] sp_c(input [1:0] c);
    sp_c = c == 2'h1 ? 11'h271 : c == 2'h2 ? 11'h138 : 11'h4e2;
endfunction
wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
req_answer_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait state");
rsvd_zero_a: assert property (rd_done && avs_address_i[7:2] == 6'h00
    |-> avs_readdata_o[31:6] == 26'h0 && avs_readdata_o[3:2] == 2'h0)
    else $error("reserved support bits read nonzero");
delay_field_a: assert property (wr_sup |=> ##1
    group_delay_select_o == $past(avs_writedata_i[5:4], 2))
    else $error("group delay select does not follow write");
rate_field_a: assert property (wr_sup |=> ##1
    update_rate_select_o == $past(avs_writedata_i[1:0], 2))
    else $error("update rate select does not follow write");
delay_cycles_a: assert property ($past(rst_n_i, 2) &&
    $stable(group_delay_select_o) && $past(group_delay_select_o) ==
    $past(group_delay_select_o, 2)
    |-> group_delay_cycles_o == gd_c(group_delay_select_o))
    else $error("group delay cycles wrong for code");
period_cycles_a: assert property ($past(rst_n_i, 2) &&
    $stable(update_rate_select_o) && $past(update_rate_select_o) ==
    $past(update_rate_select_o, 2)
    |-> sample_period_cycles_o == sp_c(update_rate_select_o))
    else $error("sample period cycles wrong for code");
debug_read_a: assert property (rd_done && avs_address_i == 8'hc0
    |-> avs_readdata_o == $past(debug_0_i))
    else $error("debug word read wrong");
unmapped_zero_a: assert property (rd_done && (avs_address_i == 8'h28
    || avs_address_i == 8'hf0) |-> avs_readdata_o == 32'h0)
    else $error("unmapped offset read nonzero");
endmodule // rcr_regs_props
`default_nettype wire

// ===== tb/rcr_host_model.sv
// Bus master standing in for the CPU software
`timescale 1ns/1ps
`default_nettype none
module rcr_host_model (
    // Clock and answer
    input wire core_clk_i,
    input wire avs_waitrequest_i,
    input wire [31:0] avs_readdata_i,
    // Request
    output logic [7:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [3:0] avs_byteenable_o,
    output logic [31:0] avs_writedata_o
);
// Idle bus from time zero
initial begin
    avs_address_o = 8'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_byteenable_o = 4'h0;
    avs_writedata_o = 32'h0;
end
// Write held until waitrequest sampled low
task automatic wr(input [7:0] a, input [3:0] be, input [31:0] d);
    @(posedge core_clk_i);
    avs_address_o <= a;
    avs_byteenable_o <= be;
    avs_writedata_o <= d;
    avs_write_o <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
    avs_write_o <= 1'b0;
endtask
// Read, data taken at the answering edge
task automatic rd(input [7:0] a, output [31:0] d);
    @(posedge core_clk_i);
    avs_address_o <= a;
    avs_byteenable_o <= 4'hf;
    avs_read_o <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
    d = avs_readdata_i;
    avs_read_o <= 1'b0;
endtask
endmodule // rcr_host_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the resolver converter register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic core_clk_i = 1'b0;
logic rst_n_i = 1'b0;
wire [7:0] adr;
wire rd, wr, wt;
wire [3:0] be;
wire [31:0] wd, rdat;
wire [1:0] gd_sel, ur_sel;
wire [15:0] gd_cyc;
wire [10:0] sp_cyc;
wire [29*32-1:0] words;
int n_mismatch = 0;
int n_tests = 0;
logic [31:0] got, exp_v;
logic [15:0] gd_t[4] = '{16'h0753, 16'h04e2, 16'h0fa0, 16'h0232};
logic [10:0] sp_t[4] = '{11'h4e2, 11'h271, 11'h138, 11'h4e2};
// Clock at 125 MHz
always #4 core_clk_i = ~core_clk_i;
rcr_host_model u_host (.core_clk_i(core_clk_i), .avs_waitrequest_i(wt),
    .avs_readdata_i(rdat), .avs_address_o(adr), .avs_read_o(rd),
    .avs_write_o(wr), .avs_byteenable_o(be), .avs_writedata_o(wd));
rcr_regs DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_byteenable_i(be), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .debug_0_i(32'hd0d00001),
    .debug_1_i(32'hd1d10002), .debug_3_i(32'hd3d30004),
    .group_delay_select_o(gd_sel), .update_rate_select_o(ur_sel),
    .group_delay_cycles_o(gd_cyc), .sample_period_cycles_o(sp_cyc),
    .ctrl_words_o(words));
// Compare one value and count it
task automatic chk(input [31:0] g, input [31:0] e);
    n_tests++;
    if (g !== e) begin
        n_mismatch++;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
// Verdict and end of run
task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask
// Expected read value of any offset from 0x04 up after the sweep
function automatic [31:0] sweep_exp(input [7:0] a);
    if ((a >= 8'h04 && a <= 8'h24) || (a >= 8'h30 && a <= 8'h64) ||
        (a >= 8'h6c && a <= 8'h74) || a == 8'hb0 || a == 8'hb4) begin
        sweep_exp = {a, ~a, 8'h5a, a};
    end else if (a == 8'hc0) begin
        sweep_exp = 32'hd0d00001;
    end else if (a == 8'hc4) begin
        sweep_exp = 32'hd1d10002;
    end else if (a == 8'hcc) begin
        sweep_exp = 32'hd3d30004;
    end else begin
        sweep_exp = 32'h0;
    end
endfunction
// Main sequence
initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    u_host.rd(8'h00, got);
    chk(got, 32'h0);
    // Every delay and rate code, reserved bits written as zero
    for (int c = 0; c < 4; c++) begin
        exp_v = {26'h0, c[1:0], 2'h0, 2'(3 - c)};
        u_host.wr(8'h00, 4'hf, exp_v);
        u_host.rd(8'h00, got);
        chk(got, exp_v);
        chk({30'h0, gd_sel}, {30'h0, c[1:0]});
        chk({30'h0, ur_sel}, {30'h0, 2'(3 - c)});
        chk({16'h0, gd_cyc}, {16'h0, gd_t[c]});
        chk({21'h0, sp_cyc}, {21'h0, sp_t[3 - c]});
    end
    // Byte lane write to the support word
    u_host.wr(8'h00, 4'h1, 32'h00000012);
    u_host.rd(8'h00, got);
    chk(got, 32'h00000012);
    // Byte and halfword lanes on a generic word
    u_host.wr(8'h04, 4'hf, 32'h11223344);
    u_host.wr(8'h04, 4'h2, 32'h0000ab00);
    u_host.wr(8'h05, 4'hc, 32'hcdef0000);
    u_host.rd(8'h04, got);
    chk(got, 32'hcdefab44);
    chk(words[31:0], 32'hcdefab44);
    // Sweep every offset from 0x04 up, support word skipped: writable, read only, unmapped
    for (int a = 4; a < 256; a += 4) begin
        u_host.wr(8'(a), 4'hf, {8'(a), ~8'(a), 8'h5a, 8'(a)});
    end
    for (int a = 4; a < 256; a += 4) begin
        u_host.rd(8'(a), got);
        chk(got, sweep_exp(8'(a)));
    end
    // Second reset in mid-run
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    u_host.rd(8'h00, got);
    chk(got, 32'h0);
    chk({28'h0, gd_sel, ur_sel}, 32'h0);
    summarize();
end
// Watchdog against a hung handshake
initial begin
    repeat (20000) @(posedge core_clk_i);
    n_mismatch++;
    summarize();
end
endmodule // testbench
bind rcr_regs rcr_regs_props u_props (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .debug_0_i(debug_0_i),
    .group_delay_select_o(group_delay_select_o),
    .update_rate_select_o(update_rate_select_o),
    .group_delay_cycles_o(group_delay_cycles_o),
    .sample_period_cycles_o(sample_period_cycles_o));
`default_nettype wire
